// ### core/sfs_filter.sv
// Deglitch filter that passes a fault level only after it has persisted.
`timescale 1ns/1ps
module sfs_filter #(
    parameter int COUNT = 200
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Raw level in, filtered level out.
    input wire logic raw,
    output logic filtered
);

    // ----------------------------------------------------------------
    // Persistence counter
    // ----------------------------------------------------------------
    localparam int W = $clog2(COUNT + 1);

    initial begin
        if (COUNT < 1) begin
            $error("Filter count must be at least one.");
        end
    end

    logic [W-1:0] cnt_r; // Cycles the raw level has stayed high.

    // The counter restarts whenever the level drops, so glitches are ignored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            filtered <= 1'b0;
        end else if (!raw) begin
            cnt_r <= '0;
            filtered <= 1'b0;
        end else if (cnt_r < W'(COUNT)) begin
            cnt_r <= cnt_r + W'(1);
            filtered <= (cnt_r == W'(COUNT - 1));
        end else begin
            filtered <= 1'b1;
        end
    end

endmodule

// ### core/sfs_supervisor.sv
// Supply fault supervisor top: fault filters, latched flags, output gating and APB registers.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "sfs_regs.svh"
// How it works
// - Filtered undervoltage switches all channels off
// - Undervoltage sets supply-low and summary flag
// - Normal mode: host rewrites on bit after clear
// - Supply-low latched until cleared and status read
// - Fail mode restarts channels automatically
// - Retry interval about 64 ms
// - Overvoltage sets supply-high and summary flag
// - Supply-high latched until cleared and status read
// - Block turn-on until pump valid, then replay
// - Filtered pump fault disables all outputs
// - Pump fault sets pump flag and summary
// - Pending turn-on runs when pump recovers, inrush
// - Pump flag latched until cleared and read
module sfs_supervisor #(
    parameter int CHANNELS = 4,
    parameter int SUPPLY_FILTER = `SFS_SUPPLY_FILTER_CYC,
    parameter int PUMP_FILTER = `SFS_PUMP_FILTER_CYC,
    parameter int RETRY_CYCLES = `SFS_RETRY_CYC
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Digitized analog indications.
    input wire logic supply_low_condition,
    input wire logic supply_high_condition,
    input wire logic pump_valid,
    // Power stage.
    output logic [CHANNELS-1:0] power_channel_outputs,
    output logic [CHANNELS-1:0] inrush_current_window,
    // Interrupt.
    output logic irq
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    initial begin
        if (CHANNELS < 1 || CHANNELS > 8) begin
            $error("Channel count must be 1 to 8.");
        end
        if (RETRY_CYCLES < 2) begin
            $error("Retry interval must be at least two cycles.");
        end
    end

    // ----------------------------------------------------------------
    // Fault filters
    // ----------------------------------------------------------------
    sfs_pkg::sfs_faults_s flt; // Filtered fault levels.

    // Undervoltage filter.
    sfs_filter #(.COUNT(SUPPLY_FILTER)) u_flt_low (
        .pclk(pclk),
        .presetn(presetn),
        .raw(supply_low_condition),
        .filtered(flt.supply_low)
    );

    // Overvoltage filter.
    sfs_filter #(.COUNT(SUPPLY_FILTER)) u_flt_high (
        .pclk(pclk),
        .presetn(presetn),
        .raw(supply_high_condition),
        .filtered(flt.supply_high)
    );

    // Charge pump filter, fed with the inverted validity.
    sfs_filter #(.COUNT(PUMP_FILTER)) u_flt_pump (
        .pclk(pclk),
        .presetn(presetn),
        .raw(!pump_valid),
        .filtered(flt.pump_bad)
    );

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic acc; // Access phase of any transfer.
    logic wr; // Write taking effect.
    logic rd; // Read taking effect.
    logic rd_quick; // Read of the quick status register.
    logic rd_dev; // Read of the device status register.
    logic wr_chan; // Write of the channel control register.
    logic mapped; // Address hits a register.

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign rd_quick = rd && (paddr == `SFS_OFF_QUICK_STATUS);
    assign rd_dev = rd && (paddr == `SFS_OFF_DEVICE_STATUS);
    assign wr_chan = wr && (paddr == `SFS_OFF_CHAN_CTRL);
    assign mapped = (paddr == `SFS_OFF_QUICK_STATUS) || (paddr == `SFS_OFF_DEVICE_STATUS) ||
                    (paddr == `SFS_OFF_CHAN_CTRL) || (paddr == `SFS_OFF_MODE) ||
                    (paddr == `SFS_OFF_IRQ_STATUS) || (paddr == `SFS_OFF_IRQ_ENABLE) ||
                    (paddr == `SFS_OFF_IRQ_CLEAR) || (paddr == `SFS_OFF_LIVE);

    // ----------------------------------------------------------------
    // Latched fault flags
    // ----------------------------------------------------------------
    logic supply_low_flag_r; // Latched undervoltage.
    logic supply_high_flag_r; // Latched overvoltage.
    logic pump_fault_flag_r; // Latched charge pump fault.
    logic device_fault_summary_flag; // Summary of the three flags.

    // Undervoltage flag: set wins, clear needs the condition gone and a read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_low_flag_r <= 1'b0;
        end else if (flt.supply_low) begin
            supply_low_flag_r <= 1'b1;
        end else if (rd_dev && !supply_low_condition) begin
            supply_low_flag_r <= 1'b0;
        end
    end

    // Overvoltage flag, same latching scheme.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_high_flag_r <= 1'b0;
        end else if (flt.supply_high) begin
            supply_high_flag_r <= 1'b1;
        end else if (rd_dev && !supply_high_condition) begin
            supply_high_flag_r <= 1'b0;
        end
    end

    // Pump flag, cleared by a quick status read once the pump is valid.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_fault_flag_r <= 1'b0;
        end else if (flt.pump_bad) begin
            pump_fault_flag_r <= 1'b1;
        end else if (rd_quick && pump_valid) begin
            pump_fault_flag_r <= 1'b0;
        end
    end

    // The summary follows the latched flags and clears with the last of them.
    assign device_fault_summary_flag = supply_low_flag_r || supply_high_flag_r || pump_fault_flag_r;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [CHANNELS-1:0] cmd_r; // Channel on commands from the host.
    logic fail_mode_r; // Fail mode selected.
    logic [2:0] irq_en_r; // Interrupt enables.

    // Host command register; undervoltage drops the commands in normal mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r <= CHANNELS'(`SFS_RST_CHAN);
        end else if (wr_chan) begin
            cmd_r <= pwdata[CHANNELS-1:0];
        end else if (flt.supply_low && !fail_mode_r) begin
            cmd_r <= '0;
        end
    end

    // Mode and interrupt enable registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_mode_r <= 1'b0;
            irq_en_r <= `SFS_RST_IRQ;
        end else if (wr && paddr == `SFS_OFF_MODE) begin
            fail_mode_r <= pwdata[`SFS_BIT_FAIL_MODE];
        end else if (wr && paddr == `SFS_OFF_IRQ_ENABLE) begin
            irq_en_r <= pwdata[2:0];
        end
    end

    // ----------------------------------------------------------------
    // Output supervisor state machine
    // ----------------------------------------------------------------
    sfs_pkg::sfs_state_e state_r; // Output path state.
    localparam int RW = $clog2(RETRY_CYCLES + 1);
    logic [RW-1:0] retry_r; // Autorestart countdown.
    logic supply_bad; // Any filtered supply fault.

    assign supply_bad = flt.supply_low || flt.supply_high;

    // Waits for the pump, runs, returns to waiting on a pump fault, and shuts down on supply faults.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= sfs_pkg::SFS_WAIT_PUMP;
            retry_r <= '0;
        end else begin
            case (state_r)
                sfs_pkg::SFS_WAIT_PUMP: begin
                    if (supply_bad) begin
                        state_r <= sfs_pkg::SFS_SHUT;
                    end else if (pump_valid) begin
                        state_r <= sfs_pkg::SFS_RUN;
                    end
                end
                sfs_pkg::SFS_RUN: begin
                    if (flt.pump_bad) begin
                        state_r <= sfs_pkg::SFS_WAIT_PUMP;
                    end else if (supply_bad) begin
                        state_r <= sfs_pkg::SFS_SHUT;
                        retry_r <= RW'(RETRY_CYCLES - 1);
                    end
                end
                sfs_pkg::SFS_SHUT: begin
                    if (supply_bad || supply_low_condition) begin
                        retry_r <= RW'(RETRY_CYCLES - 1);
                    end else if (!fail_mode_r) begin
                        state_r <= sfs_pkg::SFS_WAIT_PUMP;
                    end else if (retry_r != '0) begin
                        retry_r <= retry_r - RW'(1);
                    end else begin
                        state_r <= sfs_pkg::SFS_WAIT_PUMP;
                    end
                end
                default: begin
                    state_r <= sfs_pkg::SFS_WAIT_PUMP;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Power outputs and inrush windows
    // ----------------------------------------------------------------
    logic [CHANNELS-1:0] drive; // Channels allowed on this cycle.

    assign drive = (state_r == sfs_pkg::SFS_RUN && !flt.pump_bad && !supply_bad) ? cmd_r : '0;

    // Outputs come from flops; a rising channel marks its inrush window start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_channel_outputs <= '0;
            inrush_current_window <= '0;
        end else begin
            power_channel_outputs <= drive;
            inrush_current_window <= drive & ~power_channel_outputs;
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic [2:0] irq_st_r; // Sticky event bits.
    logic [2:0] irq_set; // Events this cycle.
    logic [2:0] irq_clr; // Clear mask written by software.

    assign irq_set = {flt.pump_bad, flt.supply_high, flt.supply_low};
    assign irq_clr = (wr && paddr == `SFS_OFF_IRQ_CLEAR) ? pwdata[2:0] : 3'h0;

    // Set wins over a simultaneous clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_r <= `SFS_RST_IRQ;
            irq <= 1'b0;
        end else begin
            irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
            irq <= |(((irq_st_r & ~irq_clr) | irq_set) & irq_en_r);
        end
    end

    // ----------------------------------------------------------------
    // APB read data and response
    // ----------------------------------------------------------------
    logic [31:0] rdat; // Read data multiplexer.

    // Selects the register addressed by the current transfer.
    always_comb begin
        rdat = 32'h0000_0000;
        case (paddr)
            `SFS_OFF_QUICK_STATUS: begin
                rdat[`SFS_BIT_PUMP_FAULT] = pump_fault_flag_r;
                rdat[`SFS_BIT_SUMMARY] = device_fault_summary_flag;
            end
            `SFS_OFF_DEVICE_STATUS: begin
                rdat[`SFS_BIT_SUPPLY_LOW] = supply_low_flag_r;
                rdat[`SFS_BIT_SUPPLY_HIGH] = supply_high_flag_r;
                rdat[`SFS_BIT_SUMMARY] = device_fault_summary_flag;
            end
            `SFS_OFF_CHAN_CTRL: begin
                rdat[CHANNELS-1:0] = cmd_r;
            end
            `SFS_OFF_MODE: begin
                rdat[`SFS_BIT_FAIL_MODE] = fail_mode_r;
            end
            `SFS_OFF_IRQ_STATUS: begin
                rdat[2:0] = irq_st_r;
            end
            `SFS_OFF_IRQ_ENABLE: begin
                rdat[2:0] = irq_en_r;
            end
            `SFS_OFF_LIVE: begin
                rdat[CHANNELS-1:0] = power_channel_outputs;
                rdat[9:8] = state_r;
                rdat[12] = pump_valid;
            end
            default: begin
                rdat = 32'h0000_0000;
            end
        endcase
    end

    // Zero-wait answer: pready and data registered in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? rdat : 32'h0000_0000;
        end
    end

endmodule

// ### inc/sfs_pkg.sv
// Types shared by the supply fault supervisor files.
package sfs_pkg;

    // Supervisor state of the output path.
    typedef enum logic [1:0] {
        SFS_WAIT_PUMP = 2'b00,
        SFS_RUN = 2'b01,
        SFS_SHUT = 2'b11
    } sfs_state_e;

    // Filtered fault levels travelling together.
    typedef struct packed {
        logic pump_bad;
        logic supply_high;
        logic supply_low;
    } sfs_faults_s;

endpackage

// ### inc/sfs_regs.svh
// Register offsets, field positions, reset values and timing counts of the supply fault supervisor.
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SFS_OFF_QUICK_STATUS 12'h000
`define SFS_OFF_DEVICE_STATUS 12'h004
`define SFS_OFF_CHAN_CTRL 12'h008
`define SFS_OFF_MODE 12'h00c
`define SFS_OFF_IRQ_STATUS 12'h010
`define SFS_OFF_IRQ_ENABLE 12'h014
`define SFS_OFF_IRQ_CLEAR 12'h018
`define SFS_OFF_LIVE 12'h01c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SFS_BIT_PUMP_FAULT 0
`define SFS_BIT_SUMMARY 7
`define SFS_BIT_SUPPLY_LOW 0
`define SFS_BIT_SUPPLY_HIGH 1
`define SFS_BIT_FAIL_MODE 0
`define SFS_IRQ_LOW 0
`define SFS_IRQ_HIGH 1
`define SFS_IRQ_PUMP 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SFS_RST_CHAN 4'h0
`define SFS_RST_IRQ 3'h0

// ----------------------------------------------------------------
// Timing: figures in their own units and derived cycle counts at 100 MHz
// ----------------------------------------------------------------
`define SFS_CLK_MHZ 100
`define SFS_SUPPLY_FILTER_NS 2000
`define SFS_PUMP_FILTER_NS 4000
`define SFS_RETRY_MS 64
`define SFS_SUPPLY_FILTER_CYC ((`SFS_SUPPLY_FILTER_NS * `SFS_CLK_MHZ + 999) / 1000)
`define SFS_PUMP_FILTER_CYC ((`SFS_PUMP_FILTER_NS * `SFS_CLK_MHZ + 999) / 1000)
`define SFS_RETRY_CYC (`SFS_RETRY_MS * 1000 * `SFS_CLK_MHZ)

`endif

// ### verification/sfs_host_model.sv
// Bus master model of the host controller.
`timescale 1ns/1ps
module sfs_host_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB master side.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // One transfer; released address and data show inverted values, never the last ones.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        while (presetn !== 1'b1) @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ### verification/sfs_supervisor_bench.sv
// Self-checking bench of the supply fault supervisor.
`timescale 1ns/1ps
`include "sfs_regs.svh"
module sfs_supervisor_bench;
    // Shortened counts.
    localparam int SF = 4;
    localparam int PF = 6;
    localparam int RT = 50;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic supply_low = 1'b0;
    logic supply_high = 1'b0;
    logic pump_valid = 1'b0;
    logic [3:0] power, inrush;
    logic bus_err;
    int errors = 0;
    int comparisons = 0;
    always #5 pclk = ~pclk;
    sfs_host_model host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sfs_supervisor #(.SUPPLY_FILTER(SF), .PUMP_FILTER(PF), .RETRY_CYCLES(RT)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_low_condition(supply_low),
        .supply_high_condition(supply_high), .pump_valid(pump_valid), .power_channel_outputs(power),
        .inrush_current_window(inrush), .irq(irq));
    // Counted comparison.
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q, bus_err);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        host.xfer(1'b0, a, 32'h0, q, bus_err);
    endtask
    // Waits a bounded time for the outputs, collecting inrush pulses.
    task automatic wait_out(input logic [3:0] x, input int lim, output logic [3:0] ir);
        int n;
        ir = 4'h0;
        n = 0;
        while (power !== x && n < lim) begin
            @(posedge pclk);
            ir = ir | inrush;
            n++;
        end
        @(posedge pclk);
        ir = ir | inrush;
        chk(power === x, "outputs did not reach expected value");
    endtask
    task automatic t_powerup();
        logic [3:0] ir;
        wr(`SFS_OFF_CHAN_CTRL, 32'hf);
        cyc(10);
        chk(power === 4'h0, "output on before pump valid");
        pump_valid <= 1'b1;
        wait_out(4'hf, 10, ir);
        chk(ir === 4'hf, "inrush missing at replay");
        $display("test powerup done");
    endtask
    task automatic t_regs();
        logic [31:0] q;
        rd(`SFS_OFF_CHAN_CTRL, q);
        chk(q[3:0] === 4'hf && bus_err === 1'b0, "command readback");
        rd(12'h020, q);
        chk(bus_err === 1'b1 && q === 32'h0, "unmapped read not refused");
        wr(12'h024, 32'h1);
        chk(bus_err === 1'b1, "unmapped write not refused");
        rd(`SFS_OFF_IRQ_CLEAR, q);
        chk(q === 32'h0, "clear register reads nonzero");
        $display("test regs done");
    endtask
    task automatic t_glitch();
        logic [31:0] q;
        supply_low <= 1'b1;
        cyc(SF - 1);
        supply_low <= 1'b0;
        cyc(6);
        chk(power === 4'hf, "short glitch switched outputs");
        rd(`SFS_OFF_DEVICE_STATUS, q);
        chk(q[0] === 1'b0, "short glitch set low flag");
        $display("test glitch done");
    endtask
    task automatic t_low();
        logic [31:0] q;
        logic [3:0] ir;
        supply_low <= 1'b1;
        cyc(SF + 6);
        chk(power === 4'h0, "outputs not off on low supply");
        rd(`SFS_OFF_DEVICE_STATUS, q);
        chk(q[0] === 1'b1 && q[7] === 1'b1, "low flag or summary missing");
        rd(`SFS_OFF_DEVICE_STATUS, q);
        chk(q[0] === 1'b1, "low flag cleared while present");
        supply_low <= 1'b0;
        cyc(10);
        chk(power === 4'h0, "restart without host write");
        rd(`SFS_OFF_DEVICE_STATUS, q);
        chk(q[0] === 1'b1, "low flag lost before read");
        rd(`SFS_OFF_DEVICE_STATUS, q);
        chk(q[0] === 1'b0, "low flag not cleared by read");
        wr(`SFS_OFF_CHAN_CTRL, 32'hf);
        wait_out(4'hf, 10, ir);
        $display("test low supply done");
    endtask
    task automatic t_high();
        logic [31:0] q;
        logic [3:0] ir;
        supply_high <= 1'b1;
        cyc(SF + 6);
        rd(`SFS_OFF_DEVICE_STATUS, q);
        chk(q[1] === 1'b1 && q[7] === 1'b1, "high flag or summary missing");
        supply_high <= 1'b0;
        cyc(3);
        rd(`SFS_OFF_DEVICE_STATUS, q);
        chk(q[1] === 1'b1, "high flag lost before read");
        rd(`SFS_OFF_DEVICE_STATUS, q);
        chk(q[1] === 1'b0, "high flag not cleared by read");
        wr(`SFS_OFF_CHAN_CTRL, 32'hf);
        wait_out(4'hf, 10, ir);
        $display("test high supply done");
    endtask
    task automatic t_pump();
        logic [31:0] q;
        logic [3:0] ir;
        pump_valid <= 1'b0;
        cyc(PF + 6);
        chk(power === 4'h0, "outputs on during pump fault");
        rd(`SFS_OFF_QUICK_STATUS, q);
        chk(q[0] === 1'b1 && q[7] === 1'b1, "pump flag or summary missing");
        wr(`SFS_OFF_CHAN_CTRL, 32'h5);
        cyc(5);
        chk(power === 4'h0, "turn-on during pump fault");
        pump_valid <= 1'b1;
        wait_out(4'h5, 10, ir);
        chk(ir === 4'h5, "inrush window mismatch");
        rd(`SFS_OFF_QUICK_STATUS, q);
        chk(q[0] === 1'b1, "pump flag lost before read");
        rd(`SFS_OFF_QUICK_STATUS, q);
        chk(q[0] === 1'b0 && q[7] === 1'b0, "pump flag or summary stuck");
        $display("test pump done");
    endtask
    task automatic t_fail();
        logic [31:0] q;
        logic [3:0] ir;
        wr(`SFS_OFF_MODE, 32'h1);
        wr(`SFS_OFF_CHAN_CTRL, 32'hf);
        wait_out(4'hf, 10, ir);
        supply_low <= 1'b1;
        cyc(SF + 6);
        supply_low <= 1'b0;
        cyc(RT - 10);
        chk(power === 4'h0, "restart before retry interval");
        wait_out(4'hf, RT + 20, ir);
        rd(`SFS_OFF_DEVICE_STATUS, q);
        chk(q[0] === 1'b1, "fail mode low flag");
        wr(`SFS_OFF_MODE, 32'h0);
        $display("test fail mode done");
    endtask
    task automatic t_irq();
        logic [31:0] q;
        rd(`SFS_OFF_IRQ_STATUS, q);
        chk(q[2:0] === 3'h7 && irq === 1'b0, "event bits or masked interrupt");
        wr(`SFS_OFF_IRQ_ENABLE, 32'h7);
        cyc(2);
        chk(irq === 1'b1, "interrupt not raised");
        wr(`SFS_OFF_IRQ_ENABLE, 32'h0);
        cyc(2);
        chk(irq === 1'b0, "interrupt not masked");
        wr(`SFS_OFF_IRQ_CLEAR, 32'h7);
        rd(`SFS_OFF_IRQ_STATUS, q);
        chk(q[2:0] === 3'h0, "event bits not cleared");
        $display("test irq done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_powerup();
        t_regs();
        t_glitch();
        t_low();
        t_high();
        t_pump();
        t_fail();
        t_irq();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        finish_test();
    end
endmodule
bind sfs_supervisor sfs_supervisor_monitor #(.CHANNELS(CHANNELS), .SUPPLY_FILTER(SUPPLY_FILTER),
    .PUMP_FILTER(PUMP_FILTER)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .supply_low_condition(supply_low_condition), .supply_high_condition(supply_high_condition),
    .pump_valid(pump_valid), .power_channel_outputs(power_channel_outputs),
    .inrush_current_window(inrush_current_window));

// ### verification/sfs_supervisor_monitor.sv
// Port checker of the supply fault supervisor.
`timescale 1ns/1ps
`include "sfs_regs.svh"
module sfs_supervisor_monitor #(
    parameter int CHANNELS = 4,
    parameter int SUPPLY_FILTER = 200,
    parameter int PUMP_FILTER = 400
) (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Indications and power stage.
    input wire logic supply_low_condition,
    input wire logic supply_high_condition,
    input wire logic pump_valid,
    input wire logic [CHANNELS-1:0] power_channel_outputs,
    input wire logic [CHANNELS-1:0] inrush_current_window
);
    // Consecutive cycles of each raw fault, saturating.
    int lo_n;
    int hi_n;
    int cp_n;
    // Completed read access.
    logic rd;
    assign rd = psel && penable && pready && !pwrite;
    // Counts restart whenever the fault drops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_n <= 0;
            hi_n <= 0;
            cp_n <= 0;
        end else begin
            lo_n <= supply_low_condition ? ((lo_n < 999) ? lo_n + 1 : lo_n) : 0;
            hi_n <= supply_high_condition ? ((hi_n < 999) ? hi_n + 1 : hi_n) : 0;
            cp_n <= !pump_valid ? ((cp_n < 999) ? cp_n + 1 : cp_n) : 0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_low_outputs_off: assert property (lo_n > SUPPLY_FILTER + 4 |-> power_channel_outputs == '0)
        else $error("outputs on during filtered low supply");
    chk_pump_outputs_off: assert property (cp_n > PUMP_FILTER + 4 |-> power_channel_outputs == '0)
        else $error("outputs on during filtered pump fault");
    chk_turnon_needs_pump: assert property ((|(power_channel_outputs & ~$past(power_channel_outputs)))
        |-> $past(pump_valid)) else $error("output turned on without valid pump");
    chk_inrush_at_turnon: assert property ((|(power_channel_outputs & ~$past(power_channel_outputs)))
        |-> ##[0:1] (|inrush_current_window)) else $error("no inrush window at turn-on");
    chk_low_flag_set: assert property (rd && paddr == `SFS_OFF_DEVICE_STATUS && lo_n > SUPPLY_FILTER + 4
        |-> prdata[0] && prdata[7]) else $error("low flag or summary missing");
    chk_high_flag_set: assert property (rd && paddr == `SFS_OFF_DEVICE_STATUS && hi_n > SUPPLY_FILTER + 4
        |-> prdata[1] && prdata[7]) else $error("high flag or summary missing");
    chk_pump_flag_set: assert property (rd && paddr == `SFS_OFF_QUICK_STATUS && cp_n > PUMP_FILTER + 4
        |-> prdata[0] && prdata[7]) else $error("pump flag or summary missing");
    chk_summary_covers_flags: assert property (rd && paddr == `SFS_OFF_DEVICE_STATUS
        && (prdata[0] || prdata[1]) |-> prdata[7]) else $error("summary low while a flag is set");
    chk_ready_one_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single access pulse");
endmodule
